// ### rtl/fpm_ctrl.sv
// Top of the flash pin, mode and protection controller with its APB registers
`timescale 1ns/10ps
`default_nettype none
`include "fpm_defs.svh"
module fpm_ctrl #(
  parameter int unsigned PROG_CYCLES  = `FPM_PROG_CYC,
  parameter int unsigned ERASE_CYCLES = `FPM_ERASE_CYC
) (
  // APB slave
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Mode, resets and straps
  input  wire logic             parallel_programming_mode,
  input  wire logic             rst_pin_n,
  input  wire logic             init_pin_n,
  input  wire logic [3:0]       chip_select_strap,
  input  wire logic [4:0]       general_inputs,
  input  wire logic             top_block_protect_n,
  input  wire logic             write_protect_n,
  // Host-bus data drivers from the cycle engine
  input  wire logic             lpc_drive_req,
  input  wire logic [3:0]       lpc_drive_data,
  output logic      [3:0]       lpc_ad_o,
  output logic                  lpc_ad_oe,
  output logic                  lpc_active,
  // Programming port pins
  input  wire logic             row_col_sel,
  input  wire logic [10:0]      muxed_address_pins,
  input  wire logic [7:0]       prog_data_bus_i,
  output logic      [7:0]       prog_data_bus_o,
  output logic                  prog_data_bus_oe,
  input  wire logic             oe_n,
  input  wire logic             we_n,
  // Memory core
  input  wire fpm_pkg::fpm_byte_t core_rd_data,
  output fpm_pkg::fpm_addr_t    core_addr,
  output fpm_pkg::fpm_byte_t    core_wr_data,
  output logic                  core_start,
  output logic                  core_erase,
  output logic                  core_abort,
  output logic                  core_busy
);
  import fpm_pkg::*;

  if (PROG_CYCLES < 1 || ERASE_CYCLES < 1) begin : g_chk
    $error("fpm_ctrl: operation cycle counts must be at least one");
  end

  logic          dev_reset;
  logic          mode_valid_q;
  logic          pp_q;
  logic          pp_en;
  logic [31:0]   status;
  logic          setup;
  logic          wr_acc;
  logic          mapped;
  fpm_addr_t     reg_addr_q;
  fpm_byte_t     reg_data_q;
  fpm_addr_t     pp_addr;
  fpm_byte_t     pp_data;
  logic          pp_wr;
  logic          req;
  logic          req_erase;
  fpm_addr_t     req_addr;
  fpm_byte_t     req_data;
  logic          blocked;
  logic          refused_q;
  logic          aborted_q;
  logic          clr_ref;
  fpm_op_state_t state_q;
  logic [31:0]   count_q;

  // Refuse when the addressed block's protect pin is low
  function automatic logic fpm_protected(input fpm_addr_t a, input logic tbl_n,
                                         input logic wp_n);
    if (a[18:16] == `FPM_TOP_BLK_HI) begin
      fpm_protected = !tbl_n; // [R7]
    end else begin
      fpm_protected = !wp_n; // [R8]
    end
  endfunction

  // Either reset pin resets the device logic
  assign dev_reset = !rst_pin_n || !init_pin_n; // [R3]

  // Interface chosen once after reset release, held until the next reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_valid_q <= 1'b0;
      pp_q         <= 1'b0;
    end else if (dev_reset) begin
      mode_valid_q <= 1'b0;
    end else if (!mode_valid_q) begin
      mode_valid_q <= 1'b1;
      pp_q         <= parallel_programming_mode; // [R16]
    end
  end

  // Only the selected interface is live
  assign pp_en      = mode_valid_q && pp_q && !dev_reset; // [R1]
  assign lpc_active = mode_valid_q && !pp_q && !dev_reset; // [R1] [R13]

  // Host-bus drivers released in reset and outside host-bus mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lpc_ad_o  <= 4'h0;
      lpc_ad_oe <= 1'b0;
    end else begin
      lpc_ad_o  <= lpc_drive_data;
      lpc_ad_oe <= lpc_active && lpc_drive_req && rst_pin_n && init_pin_n; // [R13]
    end
  end

  fpm_pp_port u_pp (
    .pclk               (pclk),
    .presetn            (presetn),
    .enable             (pp_en),
    .row_col_sel        (row_col_sel),
    .muxed_address_pins (muxed_address_pins),
    .prog_data_bus_i    (prog_data_bus_i),
    .prog_data_bus_o    (prog_data_bus_o),
    .prog_data_bus_oe   (prog_data_bus_oe),
    .oe_n               (oe_n),
    .we_n               (we_n),
    .rd_data            (core_rd_data),
    .addr               (pp_addr),
    .wr_data            (pp_data),
    .wr_strobe          (pp_wr)
  );

  // APB decode: read data captured in setup, writes taken in access
  assign setup   = psel && !penable;
  assign wr_acc  = psel && penable && pwrite;
  assign pready  = psel && penable;
  assign mapped  = paddr == `FPM_OFS_STATUS || paddr == `FPM_OFS_GPI ||
                   paddr == `FPM_OFS_ADDR || paddr == `FPM_OFS_DATA ||
                   paddr == `FPM_OFS_CMD;
  assign pslverr = pready && !mapped;
  assign clr_ref = wr_acc && paddr == `FPM_OFS_CMD && pwdata[`FPM_CMD_CLR_REF];

  // Status word assembled from live block state
  always_comb begin
    status                      = `FPM_ZERO32;
    status[`FPM_ST_PP]          = pp_q;
    status[`FPM_ST_BUSY]        = state_q == FPM_BUSY;
    status[`FPM_ST_REFUSED]     = refused_q;
    status[`FPM_ST_ABORTED]     = aborted_q;
    status[`FPM_ST_TBL]         = top_block_protect_n;
    status[`FPM_ST_WP]          = write_protect_n;
    status[`FPM_ST_STRAP_LSB +: 4] = chip_select_strap;
  end

  // Read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `FPM_ZERO32;
    end else if (setup && !pwrite) begin
      case (paddr)
        `FPM_OFS_STATUS: prdata <= status;
        `FPM_OFS_GPI:    prdata <= {27'h0000000, general_inputs}; // [R5]
        `FPM_OFS_ADDR:   prdata <= {13'h0000, reg_addr_q};
        `FPM_OFS_DATA:   prdata <= {24'h000000, reg_data_q};
        default:         prdata <= `FPM_ZERO32;
      endcase
    end
  end

  // Address and data registers for host-side program requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_addr_q <= 19'h00000;
      reg_data_q <= 8'h00;
    end else if (wr_acc) begin
      if (paddr == `FPM_OFS_ADDR) begin
        reg_addr_q <= pwdata[18:0];
      end
      if (paddr == `FPM_OFS_DATA) begin
        reg_data_q <= pwdata[7:0];
      end
    end
  end

  // Request source follows the selected interface
  always_comb begin
    req       = 1'b0;
    req_erase = 1'b0;
    req_addr  = reg_addr_q;
    req_data  = reg_data_q;
    if (pp_en) begin
      req      = pp_wr; // [R1]
      req_addr = pp_addr;
      req_data = pp_data;
    end else if (lpc_active && wr_acc && paddr == `FPM_OFS_CMD) begin
      req       = pwdata[`FPM_CMD_PROG] || pwdata[`FPM_CMD_ERASE];
      req_erase = pwdata[`FPM_CMD_ERASE];
    end
  end

  assign blocked = fpm_protected(req_addr, top_block_protect_n, write_protect_n);

  // Operation sequencer: start, timed run, abort on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q      <= FPM_IDLE;
      count_q      <= `FPM_ZERO32;
      core_start   <= 1'b0;
      core_abort   <= 1'b0;
      core_erase   <= 1'b0;
      core_addr    <= 19'h00000;
      core_wr_data <= 8'h00;
    end else begin
      core_start <= 1'b0;
      core_abort <= 1'b0;
      if (!pp_en) begin
        core_addr <= req_addr;
      end else if (state_q == FPM_IDLE) begin
        core_addr <= pp_addr;
      end
      case (state_q)
        FPM_IDLE: begin
          if (req && !blocked && !dev_reset) begin // [R17]
            state_q      <= FPM_BUSY;
            core_start   <= 1'b1;
            core_erase   <= req_erase;
            core_addr    <= req_addr;
            core_wr_data <= req_data;
            count_q      <= req_erase ? ERASE_CYCLES - 1 : PROG_CYCLES - 1;
          end
        end
        FPM_BUSY: begin
          if (dev_reset) begin
            state_q    <= FPM_IDLE; // [R14]
            core_abort <= 1'b1;
          end else if (count_q == `FPM_ZERO32) begin
            state_q <= FPM_IDLE;
          end else begin
            count_q <= count_q - 32'h0000_0001;
          end
        end
        default: state_q <= FPM_IDLE;
      endcase
    end
  end

  assign core_busy = state_q == FPM_BUSY;

  // Sticky refused and aborted flags; a new event wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refused_q <= 1'b0;
      aborted_q <= 1'b0;
    end else begin
      if (req && blocked && state_q == FPM_IDLE) begin
        refused_q <= 1'b1; // [R17]
      end else if (clr_ref) begin
        refused_q <= 1'b0;
      end
      if (state_q == FPM_BUSY && dev_reset) begin
        aborted_q <= 1'b1; // [R14]
      end else if (clr_ref) begin
        aborted_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/fpm_defs.svh
// Constants of the flash pin, mode and protection controller
// What this block does
// (R1) Run the programming port when the select pin is high, else the host-bus side.
// (R2) Outside party sets the select pin before reset release and never changes it.
// (R3) The second reset pin acts exactly like the primary reset pin.
// (R4) Outside party straps the boot device select straps to zero, others counting up.
// (R5) The five general inputs are readable by the host through a register.
// (R6) Outside party keeps the general inputs steady around their register read.
// (R7) Top-block protect pin low refuses programming of the top boot block.
// (R8) Write-protect pin low refuses programming of every block below the top.
// (R9) In programming mode the row/column pin says which address half is present.
// (R10) Address halves are latched by the row/column pin and held during a write.
// (R11) The eight data pins are latched during a write, under write-enable control.
// (R12) Read data is driven only while output enable is low, else released.
// (R13) Either reset releases the host-bus data drivers and deselects the device.
// (R14) A reset during a program or erase aborts that operation.
// (R15) Column half maps to the upper address bits, row half to the lower.
// (R16) The select pin is sampled at reset release and held until next reset.
// (R17) A protected program request leaves memory alone and starts no operation.
`ifndef FPM_DEFS_SVH
`define FPM_DEFS_SVH
`define FPM_ADDR_W        19
`define FPM_ROW_W         11
`define FPM_COL_W         8
`define FPM_TOP_BLK_HI    3'h7
`define FPM_OFS_STATUS    12'h000
`define FPM_OFS_GPI       12'h004
`define FPM_OFS_ADDR      12'h008
`define FPM_OFS_DATA      12'h00C
`define FPM_OFS_CMD       12'h010
`define FPM_CMD_PROG      0
`define FPM_CMD_ERASE     1
`define FPM_CMD_CLR_REF   2
`define FPM_ST_PP         0
`define FPM_ST_BUSY       1
`define FPM_ST_REFUSED    2
`define FPM_ST_ABORTED    3
`define FPM_ST_TBL        4
`define FPM_ST_WP         5
`define FPM_ST_STRAP_LSB  8
`define FPM_CLK_NS        4
`define FPM_PROG_TIME_NS  20000
`define FPM_ERASE_TIME_NS 18000000
`define FPM_PROG_CYC      ((`FPM_PROG_TIME_NS + `FPM_CLK_NS - 1) / `FPM_CLK_NS)
`define FPM_ERASE_CYC     ((`FPM_ERASE_TIME_NS + `FPM_CLK_NS - 1) / `FPM_CLK_NS)
`define FPM_ZERO32        32'h0000_0000
`endif

// ### rtl/fpm_pkg.sv
// Types shared by the flash pin, mode and protection controller
package fpm_pkg;
  typedef logic [18:0] fpm_addr_t;
  typedef logic [7:0]  fpm_byte_t;
  typedef enum logic [1:0] {
    FPM_IDLE,
    FPM_BUSY
  } fpm_op_state_t;
endpackage

// ### rtl/fpm_pp_port.sv
// Parallel programming port: address halves, data latch and output gating
`timescale 1ns/10ps
`default_nettype none
`include "fpm_defs.svh"
module fpm_pp_port (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             enable,
  // Programming pins
  input  wire logic             row_col_sel,
  input  wire logic [10:0]      muxed_address_pins,
  input  wire logic [7:0]       prog_data_bus_i,
  output logic      [7:0]       prog_data_bus_o,
  output logic                  prog_data_bus_oe,
  input  wire logic             oe_n,
  input  wire logic             we_n,
  // Core side
  input  wire fpm_pkg::fpm_byte_t rd_data,
  output fpm_pkg::fpm_addr_t    addr,
  output fpm_pkg::fpm_byte_t    wr_data,
  output logic                  wr_strobe
);
  import fpm_pkg::*;
  logic [10:0] row_q;
  logic [7:0]  col_q;
  logic        we_n_q;

  // Halves follow the pins by row/column level, frozen while a write is open
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_q <= 11'h000;
      col_q <= 8'h00;
    end else if (enable && we_n) begin
      if (row_col_sel) begin
        row_q <= muxed_address_pins; // [R9] [R10]
      end else begin
        col_q <= muxed_address_pins[7:0]; // [R9] [R10]
      end
    end
  end

  // Data caught while write enable is low, strobe at its rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      we_n_q    <= 1'b1;
      wr_data   <= 8'h00;
      wr_strobe <= 1'b0;
    end else begin
      we_n_q    <= we_n;
      wr_strobe <= enable && we_n && !we_n_q; // [R11]
      if (enable && !we_n) begin
        wr_data <= prog_data_bus_i; // [R11]
      end
    end
  end

  // Column to upper bits, row to lower bits
  assign addr = {col_q, row_q}; // [R15]

  // Read data registered; drivers on only while output enable is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_data_bus_o  <= 8'h00;
      prog_data_bus_oe <= 1'b0;
    end else begin
      prog_data_bus_o  <= rd_data;
      prog_data_bus_oe <= enable && !oe_n && we_n; // [R12]
    end
  end
endmodule
`default_nettype wire

// ### test/fpm_chk.sv
// Port assertions of the flash pin, mode and protection controller
`timescale 1ns/10ps
`default_nettype none
module fpm_chk #(
  parameter int unsigned PROG_CYCLES  = 4,
  parameter int unsigned ERASE_CYCLES = 8
) (
  // Clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // Mode, reset and protect pins
  input wire logic               parallel_programming_mode,
  input wire logic               rst_pin_n,
  input wire logic               init_pin_n,
  input wire logic               top_block_protect_n,
  input wire logic               write_protect_n,
  input wire logic               lpc_ad_oe,
  input wire logic               lpc_active,
  // Programming port
  input wire logic               row_col_sel,
  input wire logic [10:0]        muxed_address_pins,
  input wire logic               prog_data_bus_oe,
  input wire logic               oe_n,
  input wire logic               we_n,
  // Core side
  input wire fpm_pkg::fpm_addr_t core_addr,
  input wire logic               core_start,
  input wire logic               core_abort,
  input wire logic               core_busy
);
  import fpm_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Either reset pin low
  wire pin_rst = !rst_pin_n || !init_pin_n;
  // Quiet programming port: no write open, no operation running, no pin reset
  wire pp_idle = parallel_programming_mode && we_n && !core_busy && !pin_rst;
  // Output enable asserted with no write open
  wire rd_gate = !oe_n && we_n;

  a_lpc_off_pp: assert property (lpc_active |-> !parallel_programming_mode)
    else $error("host side active in programming mode");
  a_pp_no_drive: assert property (!parallel_programming_mode |=> !prog_data_bus_oe)
    else $error("data bus driven outside programming mode");
  a_pin_release: assert property (pin_rst |=> !lpc_ad_oe)
    else $error("host drivers kept on under pin reset");
  a_abort_pulse: assert property (core_busy && pin_rst |=> core_abort)
    else $error("running operation not aborted");
  a_prot_gate: assert property (core_start |->
    (&core_addr[18:16] ? top_block_protect_n : write_protect_n))
    else $error("operation started on protected block");
  a_oe_gate: assert property (prog_data_bus_oe |-> $past(rd_gate))
    else $error("data bus driven without output enable");
  a_col_map: assert property (
    (pp_idle && !row_col_sel && $stable(muxed_address_pins))[*3]
    |-> core_addr[18:11] == muxed_address_pins[7:0])
    else $error("column half not on upper address bits");
  a_row_map: assert property (
    (pp_idle && row_col_sel && $stable(muxed_address_pins))[*3]
    |-> core_addr[10:0] == muxed_address_pins)
    else $error("row half not on lower address bits");
  a_addr_hold: assert property (
    (parallel_programming_mode && !we_n && !pin_rst)[*3] |-> $stable(core_addr))
    else $error("address moved during write");

  // Main scenarios reached
  c_start: cover property (core_start);
  c_abort: cover property (core_abort);
  c_pp_read: cover property (prog_data_bus_oe);
endmodule
bind fpm_ctrl fpm_chk #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) u_chk (
  .pclk, .presetn, .parallel_programming_mode, .rst_pin_n, .init_pin_n,
  .top_block_protect_n, .write_protect_n, .lpc_ad_oe, .lpc_active, .row_col_sel,
  .muxed_address_pins, .prog_data_bus_oe, .oe_n, .we_n, .core_addr, .core_start,
  .core_abort, .core_busy);
`default_nettype wire

// ### test/fpm_core_model.sv
// Memory array stand-in answering reads of the controller
`timescale 1ns/10ps
`default_nettype none
module fpm_core_model (
  // Clock
  input  wire logic               pclk,
  // Core side
  input  wire fpm_pkg::fpm_addr_t core_addr,
  output fpm_pkg::fpm_byte_t      core_rd_data
);
  import fpm_pkg::*;
  // Array byte follows the address one cycle later
  always_ff @(posedge pclk) begin
    core_rd_data <= core_addr[7:0] ^ core_addr[18:11];
  end
endmodule
`default_nettype wire

// ### test/tb.sv
// Self-checking bench of the flash pin, mode and protection controller
`timescale 1ns/10ps
`default_nettype none
module tb;
  import fpm_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, a, d;
  logic        parallel_programming_mode, rst_pin_n, init_pin_n;
  logic [3:0]  chip_select_strap, lpc_drive_data, lpc_ad_o;
  logic [4:0]  general_inputs;
  logic        top_block_protect_n, write_protect_n, lpc_drive_req, lpc_ad_oe, lpc_active;
  logic        row_col_sel, prog_data_bus_oe, oe_n, we_n;
  logic [10:0] muxed_address_pins;
  logic [7:0]  prog_data_bus_i, prog_data_bus_o;
  fpm_byte_t   core_rd_data, core_wr_data;
  fpm_addr_t   core_addr, start_addr;
  logic        core_start, core_erase, core_abort, core_busy;
  int          err_count = 0, n_checks = 0, seed = 91, starts = 0, aborts = 0, n;

  fpm_ctrl #(.PROG_CYCLES(4), .ERASE_CYCLES(8)) u_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .parallel_programming_mode,
    .rst_pin_n, .init_pin_n, .chip_select_strap, .general_inputs, .top_block_protect_n,
    .write_protect_n, .lpc_drive_req, .lpc_drive_data, .lpc_ad_o, .lpc_ad_oe, .lpc_active,
    .row_col_sel, .muxed_address_pins, .prog_data_bus_i, .prog_data_bus_o,
    .prog_data_bus_oe, .oe_n, .we_n, .core_rd_data, .core_addr, .core_wr_data,
    .core_start, .core_erase, .core_abort, .core_busy);
  fpm_core_model u_core (.pclk, .core_addr, .core_rd_data);

  // Clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Count operation starts and aborts
  always @(posedge pclk) begin
    if (core_start === 1'b1) begin
      starts++;
      start_addr = core_addr;
    end
    if (core_abort === 1'b1) aborts++;
  end

  // Expected array byte for an address
  function automatic logic [31:0] rd_exp(input logic [31:0] ad);
    return {24'h0, ad[7:0] ^ ad[18:11]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic end_sim;
    if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Watchdog
  initial begin
    cyc(5000);
    err_count++;
    end_sim();
  end

  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, lpc_drive_req, lpc_drive_data} = '0;
    {parallel_programming_mode, general_inputs, row_col_sel, muxed_address_pins} = '0;
    {rst_pin_n, init_pin_n, top_block_protect_n, write_protect_n, oe_n, we_n} = '1;
    prog_data_bus_i = 8'h00;
    chip_select_strap = 4'h0;
    cyc(3);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk("status", r, 32'h0000_0030);
    for (int i = 0; i < 6; i++) begin
      general_inputs <= (i == 0) ? 5'h1F : 5'($random(seed));
      apb(1'b0, 12'h004, 32'h0);
      chk("gpi", r, {27'h0, general_inputs});
    end
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", {r[30:0], e}, 32'h1);
    d = $random(seed);
    apb(1'b1, 12'h00C, d);
    apb(1'b0, 12'h00C, 32'h0);
    chk("data rb", r, {24'h0, d[7:0]});
    for (int i = 0; i < 8; i++) begin
      top_block_protect_n <= i[0];
      write_protect_n <= i[1];
      a = $random(seed);
      a[18:16] = i[2] ? 3'h7 : {1'b0, a[17:16]};
      apb(1'b1, 12'h008, a);
      apb(1'b0, 12'h008, 32'h0);
      chk("addr rb", r, {13'h0, a[18:0]});
      n = starts;
      apb(1'b1, 12'h010, i[0] ? 32'h1 : 32'h2);
      cyc(12);
      chk("start", 32'(starts - n), {31'h0, i[2] ? i[0] : i[1]});
      apb(1'b0, 12'h000, 32'h0);
      chk("refused", {31'h0, r[2]}, {31'h0, !(i[2] ? i[0] : i[1])});
      apb(1'b1, 12'h010, 32'h4);
    end
    chk("host wdata", {24'h0, core_wr_data}, {24'h0, d[7:0]});
    for (int p = 0; p < 2; p++) begin
      n = aborts;
      apb(1'b1, 12'h010, 32'h2);
      cyc(3);
      chk("busy", {31'h0, core_busy}, 32'h1);
      chk("erase", {31'h0, core_erase}, 32'h1);
      if (p == 0) rst_pin_n <= 1'b0;
      else init_pin_n <= 1'b0;
      cyc(2);
      {rst_pin_n, init_pin_n} <= 2'b11;
      cyc(3);
      chk("abort", 32'(aborts - n), 32'h1);
      chk("idle", {31'h0, core_busy}, 32'h0);
      apb(1'b0, 12'h000, 32'h0);
      chk("aborted", {31'h0, r[3]}, 32'h1);
      apb(1'b1, 12'h010, 32'h4);
    end
    lpc_drive_req <= 1'b1;
    lpc_drive_data <= 4'($random(seed));
    cyc(3);
    chk("lpc drive", {27'h0, lpc_ad_oe, lpc_ad_o}, {28'h1, lpc_drive_data});
    init_pin_n <= 1'b0;
    cyc(3);
    chk("lpc release", {31'h0, lpc_ad_oe}, 32'h0);
    {init_pin_n, rst_pin_n} <= 2'b10;
    lpc_drive_req <= 1'b0;
    cyc(1);
    parallel_programming_mode <= 1'b1;
    cyc(1);
    rst_pin_n <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk("pp mode", {30'h0, lpc_active, r[0]}, 32'h1);
    a = $random(seed);
    row_col_sel <= 1'b1;
    muxed_address_pins <= a[10:0];
    cyc(4);
    row_col_sel <= 1'b0;
    muxed_address_pins <= {3'h0, a[18:11]};
    cyc(4);
    chk("pp addr", {13'h0, core_addr}, {13'h0, a[18:0]});
    n = starts;
    prog_data_bus_i <= a[26:19];
    we_n <= 1'b0;
    cyc(2);
    muxed_address_pins <= ~a[10:0];
    cyc(2);
    muxed_address_pins <= {3'h0, a[18:11]};
    we_n <= 1'b1;
    cyc(4);
    chk("pp wdata", {24'h0, core_wr_data}, {24'h0, a[26:19]});
    chk("pp waddr", {13'h0, start_addr}, {13'h0, a[18:0]});
    apb(1'b1, 12'h010, 32'h1);
    cyc(12);
    chk("pp starts", 32'(starts - n), 32'h1);
    chk("pp prog", {31'h0, core_erase}, 32'h0);
    oe_n <= 1'b0;
    cyc(4);
    chk("pp read", {23'h0, prog_data_bus_oe, prog_data_bus_o}, 32'h100 | rd_exp(a));
    oe_n <= 1'b1;
    cyc(3);
    chk("pp release", {31'h0, prog_data_bus_oe}, 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
